// ---- dab_pkg.sv ----
// shared opcode patterns, decode types and reset values for the decoder
package dab_pkg;

	// ----------------------------------------------------------------
	// widths
	// ----------------------------------------------------------------
	localparam int WORD_W = 16;
	localparam int ACC_W = 32;

	// ----------------------------------------------------------------
	// opcode patterns: a word matches when (word & mask) == value
	// ----------------------------------------------------------------
	localparam logic [15:0] MSK_BYTE = 16'hff00;
	localparam logic [15:0] MSK_FULL = 16'hffff;
	localparam logic [15:0] MSK_JUMP = 16'hff80;
	localparam logic [15:0] PAT_AUX_ADD_SHORT_IMM = 16'h7e00;
	localparam logic [15:0] PAT_AUX_COMPARE_ZERO_REG = 16'hce50;
	localparam logic [15:0] MSK_AUX_COMPARE_ZERO_REG = 16'hfffc;
	localparam logic [15:0] PAT_PAGE_PTR_LOAD_IMM = 16'hc800;
	localparam logic [15:0] MSK_PAGE_PTR_LOAD_IMM = 16'hfe00;
	localparam logic [15:0] PAT_PAGE_PTR_LOAD_MEM = 16'h5200;
	localparam logic [15:0] PAT_AUX_POINTER_LOAD = 16'h5500;
	localparam logic [15:0] PAT_AUX_LOAD_LONG_IMM = 16'hd000;
	localparam logic [15:0] MSK_AUX_LOAD_LONG_IMM = 16'hf8ff;
	localparam logic [15:0] PAT_MCAND_LOAD_ACC_MOVE = 16'h3f00;
	localparam logic [15:0] PAT_MCAND_LOAD_PROD_TO_ACC = 16'h3e00;
	localparam logic [15:0] PAT_MCAND_LOAD_SUB_PROD = 16'h5b00;
	localparam logic [15:0] PAT_MULT_ACC_WITH_MOVE = 16'h7c00;
	localparam logic [15:0] PAT_MULT_ADD_PREV_PROD = 16'h3a00;
	localparam logic [15:0] PAT_MULT_SUB_PREV_PROD = 16'h3b00;
	localparam logic [15:0] PAT_PROD_ADD_TO_ACC = 16'hce14;
	localparam logic [15:0] PAT_JUMP_VIA_ACC = 16'hce25;
	localparam logic [15:0] PAT_JUMP_AUX_NONZERO = 16'hfb80;
	localparam logic [15:0] PAT_JUMP_FLAG_CLEAR = 16'hf880;
	localparam logic [15:0] PAT_JUMP_ACC_POSITIVE = 16'hf180;
	localparam logic [15:0] PAT_JUMP_ACC_NEGATIVE = 16'hf380;

	// ----------------------------------------------------------------
	// field positions
	// ----------------------------------------------------------------
	localparam int POS_INDIRECT = 7;
	localparam int POS_AUX_SEL = 8;

	// ----------------------------------------------------------------
	// types
	// ----------------------------------------------------------------
	typedef enum logic [4:0] {
		DAB_OP_NONE, DAB_OP_AUX_ADD_SHORT_IMM, DAB_OP_AUX_COMPARE_ZERO_REG,
		DAB_OP_PAGE_PTR_LOAD_IMM, DAB_OP_PAGE_PTR_LOAD_MEM, DAB_OP_AUX_POINTER_LOAD,
		DAB_OP_AUX_LOAD_LONG_IMM, DAB_OP_MCAND_LOAD_ACC_MOVE, DAB_OP_MCAND_LOAD_PROD_TO_ACC,
		DAB_OP_MCAND_LOAD_SUB_PROD, DAB_OP_MULT_ACC_WITH_MOVE, DAB_OP_MULT_ADD_PREV_PROD,
		DAB_OP_MULT_SUB_PREV_PROD, DAB_OP_PROD_ADD_TO_ACC, DAB_OP_JUMP_VIA_ACC,
		DAB_OP_JUMP_AUX_NONZERO, DAB_OP_JUMP_FLAG_CLEAR, DAB_OP_JUMP_ACC_POSITIVE,
		DAB_OP_JUMP_ACC_NEGATIVE
	} dab_op_t;

	typedef enum logic [1:0] {
		DAB_ST_FIRST = 2'b01,
		DAB_ST_SECOND = 2'b10
	} dab_state_t;

	typedef struct packed {
		dab_op_t op;
		logic [15:0] imm;
		logic [1:0] cmp_cond;
		logic indirect;
		logic [6:0] mem_field;
		logic [2:0] aux_sel;
	} dab_dec_t;

	// ----------------------------------------------------------------
	// reset values
	// ----------------------------------------------------------------
	localparam dab_dec_t RST_DEC = '{DAB_OP_NONE, 16'h0000, 2'h0, 1'b0, 7'h00, 3'h0};
	localparam logic [15:0] RST_WORD = 16'h0000;

endpackage : dab_pkg

// ---- dab_decoder.sv ----
// opcode decoder for auxiliary-register, multiplier and branch instruction groups
`timescale 1ns/1ps

module dab_decoder (
	// clock, reset, enable
	input wire logic clk,
	input wire logic reset_n,
	input wire logic clk_en,
	// fetched words
	input wire logic word_valid,
	input wire logic [15:0] word,
	// machine state for branch conditions
	input wire logic [15:0] aux_cur,
	input wire logic [31:0] acc,
	input wire logic test_control_flag,
	// decode result
	output dab_pkg::dab_dec_t dec,
	output logic dec_valid,
	output logic fetch_second,
	// program counter load
	output logic pc_load,
	output logic [15:0] pc_target,
	output logic branch_via_acc
);

	// ----------------------------------------------------------------
	// helpers
	// ----------------------------------------------------------------
	function automatic logic op_match(input logic [15:0] w, input logic [15:0] m,
		input logic [15:0] p);
		op_match = (w & m) == p;
	endfunction : op_match

	function automatic logic is_two_word(input dab_pkg::dab_op_t op);
		case (op)
			dab_pkg::DAB_OP_AUX_LOAD_LONG_IMM, dab_pkg::DAB_OP_MULT_ACC_WITH_MOVE,
			dab_pkg::DAB_OP_JUMP_AUX_NONZERO, dab_pkg::DAB_OP_JUMP_FLAG_CLEAR,
			dab_pkg::DAB_OP_JUMP_ACC_POSITIVE, dab_pkg::DAB_OP_JUMP_ACC_NEGATIVE:
				is_two_word = 1'b1;
			default:
				is_two_word = 1'b0;
		endcase
	endfunction : is_two_word

	function automatic logic is_jump(input dab_pkg::dab_op_t op);
		is_jump = (op == dab_pkg::DAB_OP_JUMP_AUX_NONZERO)
			|| (op == dab_pkg::DAB_OP_JUMP_FLAG_CLEAR)
			|| (op == dab_pkg::DAB_OP_JUMP_ACC_POSITIVE)
			|| (op == dab_pkg::DAB_OP_JUMP_ACC_NEGATIVE);
	endfunction : is_jump

	// ----------------------------------------------------------------
	// first-word decode
	// ----------------------------------------------------------------
	dab_pkg::dab_state_t state;
	dab_pkg::dab_dec_t held;
	dab_pkg::dab_op_t next_op;
	dab_pkg::dab_dec_t next_dec;
	logic take_first;
	logic take_second;
	logic cond_aux_nz;
	logic cond_flag_clear;
	logic cond_acc_pos;
	logic cond_acc_neg;
	logic next_cond;

	assign take_first = clk_en && word_valid && (state == dab_pkg::DAB_ST_FIRST);
	assign take_second = clk_en && word_valid && (state == dab_pkg::DAB_ST_SECOND);

	always_comb begin
		next_op = dab_pkg::DAB_OP_NONE;
		if (op_match(word, dab_pkg::MSK_BYTE, dab_pkg::PAT_AUX_ADD_SHORT_IMM)) begin
			next_op = dab_pkg::DAB_OP_AUX_ADD_SHORT_IMM;
		end else if (op_match(word, dab_pkg::MSK_AUX_COMPARE_ZERO_REG,
			dab_pkg::PAT_AUX_COMPARE_ZERO_REG)) begin
			next_op = dab_pkg::DAB_OP_AUX_COMPARE_ZERO_REG;
		end else if (op_match(word, dab_pkg::MSK_PAGE_PTR_LOAD_IMM,
			dab_pkg::PAT_PAGE_PTR_LOAD_IMM)) begin
			next_op = dab_pkg::DAB_OP_PAGE_PTR_LOAD_IMM;
		end else if (op_match(word, dab_pkg::MSK_BYTE, dab_pkg::PAT_PAGE_PTR_LOAD_MEM)) begin
			next_op = dab_pkg::DAB_OP_PAGE_PTR_LOAD_MEM;
		end else if (op_match(word, dab_pkg::MSK_BYTE, dab_pkg::PAT_AUX_POINTER_LOAD)) begin
			next_op = dab_pkg::DAB_OP_AUX_POINTER_LOAD;
		end else if (op_match(word, dab_pkg::MSK_AUX_LOAD_LONG_IMM,
			dab_pkg::PAT_AUX_LOAD_LONG_IMM)) begin
			next_op = dab_pkg::DAB_OP_AUX_LOAD_LONG_IMM;
		end else if (op_match(word, dab_pkg::MSK_BYTE, dab_pkg::PAT_MCAND_LOAD_ACC_MOVE)) begin
			next_op = dab_pkg::DAB_OP_MCAND_LOAD_ACC_MOVE;
		end else if (op_match(word, dab_pkg::MSK_BYTE,
			dab_pkg::PAT_MCAND_LOAD_PROD_TO_ACC)) begin
			next_op = dab_pkg::DAB_OP_MCAND_LOAD_PROD_TO_ACC;
		end else if (op_match(word, dab_pkg::MSK_BYTE, dab_pkg::PAT_MCAND_LOAD_SUB_PROD)) begin
			next_op = dab_pkg::DAB_OP_MCAND_LOAD_SUB_PROD;
		end else if (op_match(word, dab_pkg::MSK_BYTE, dab_pkg::PAT_MULT_ACC_WITH_MOVE)) begin
			next_op = dab_pkg::DAB_OP_MULT_ACC_WITH_MOVE;
		end else if (op_match(word, dab_pkg::MSK_BYTE, dab_pkg::PAT_MULT_ADD_PREV_PROD)) begin
			next_op = dab_pkg::DAB_OP_MULT_ADD_PREV_PROD;
		end else if (op_match(word, dab_pkg::MSK_BYTE, dab_pkg::PAT_MULT_SUB_PREV_PROD)) begin
			next_op = dab_pkg::DAB_OP_MULT_SUB_PREV_PROD;
		end else if (op_match(word, dab_pkg::MSK_FULL, dab_pkg::PAT_PROD_ADD_TO_ACC)) begin
			next_op = dab_pkg::DAB_OP_PROD_ADD_TO_ACC;
		end else if (op_match(word, dab_pkg::MSK_FULL, dab_pkg::PAT_JUMP_VIA_ACC)) begin
			next_op = dab_pkg::DAB_OP_JUMP_VIA_ACC;
		end else if (op_match(word, dab_pkg::MSK_JUMP, dab_pkg::PAT_JUMP_AUX_NONZERO)) begin
			next_op = dab_pkg::DAB_OP_JUMP_AUX_NONZERO;
		end else if (op_match(word, dab_pkg::MSK_JUMP, dab_pkg::PAT_JUMP_FLAG_CLEAR)) begin
			next_op = dab_pkg::DAB_OP_JUMP_FLAG_CLEAR;
		end else if (op_match(word, dab_pkg::MSK_JUMP, dab_pkg::PAT_JUMP_ACC_POSITIVE)) begin
			next_op = dab_pkg::DAB_OP_JUMP_ACC_POSITIVE;
		end else if (op_match(word, dab_pkg::MSK_JUMP, dab_pkg::PAT_JUMP_ACC_NEGATIVE)) begin
			next_op = dab_pkg::DAB_OP_JUMP_ACC_NEGATIVE;
		end
	end

	// operand fields; immediates that come from the first word are filled here
	always_comb begin
		next_dec = dab_pkg::RST_DEC;
		next_dec.op = next_op;
		next_dec.indirect = word[dab_pkg::POS_INDIRECT];
		next_dec.mem_field = word[6:0];
		next_dec.aux_sel = word[dab_pkg::POS_AUX_SEL +: 3];
		next_dec.cmp_cond = word[1:0];
		case (next_op)
			dab_pkg::DAB_OP_AUX_ADD_SHORT_IMM:
				next_dec.imm = {8'h00, word[7:0]};
			dab_pkg::DAB_OP_PAGE_PTR_LOAD_IMM:
				next_dec.imm = {7'h00, word[8:0]};
			default:
				next_dec.imm = 16'h0000;
		endcase
	end

	// ----------------------------------------------------------------
	// branch conditions, sampled with the second word
	// ----------------------------------------------------------------
	assign cond_aux_nz = aux_cur != 16'h0000;
	assign cond_flag_clear = !test_control_flag;
	assign cond_acc_pos = $signed(acc) > 32'sd0;
	assign cond_acc_neg = acc[31];

	always_comb begin
		case (held.op)
			dab_pkg::DAB_OP_JUMP_AUX_NONZERO:
				next_cond = cond_aux_nz;
			dab_pkg::DAB_OP_JUMP_FLAG_CLEAR:
				next_cond = cond_flag_clear;
			dab_pkg::DAB_OP_JUMP_ACC_POSITIVE:
				next_cond = cond_acc_pos;
			dab_pkg::DAB_OP_JUMP_ACC_NEGATIVE:
				next_cond = cond_acc_neg;
			default:
				next_cond = 1'b0;
		endcase
	end

	// ----------------------------------------------------------------
	// word sequencing
	// ----------------------------------------------------------------
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			state <= dab_pkg::DAB_ST_FIRST;
		end else if (clk_en) begin
			case (state)
				dab_pkg::DAB_ST_FIRST: begin
					if (word_valid && is_two_word(next_op)) begin
						state <= dab_pkg::DAB_ST_SECOND;
					end
				end
				dab_pkg::DAB_ST_SECOND: begin
					if (word_valid) begin
						state <= dab_pkg::DAB_ST_FIRST;
					end
				end
				default:
					state <= dab_pkg::DAB_ST_FIRST;
			endcase
		end
	end

	// first word of a pair waits here until its second word arrives
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			held <= dab_pkg::RST_DEC;
		end else if (take_first) begin
			held <= next_dec;
		end
	end

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			fetch_second <= 1'b0;
		end else if (clk_en) begin
			fetch_second <= take_first ? is_two_word(next_op) : (fetch_second && !word_valid);
		end
	end

	// ----------------------------------------------------------------
	// decode result
	// ----------------------------------------------------------------
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			dec <= dab_pkg::RST_DEC;
			dec_valid <= 1'b0;
		end else if (clk_en) begin
			if (take_first && !is_two_word(next_op)) begin
				dec <= next_dec;
				dec_valid <= 1'b1;
			end else if (take_second) begin
				dec <= held;
				dec.imm <= word;
				dec_valid <= 1'b1;
			end else begin
				dec_valid <= 1'b0;
			end
		end
	end

	// the counter is loaded only for a taken jump pair; the accumulator jump raises branch_via_acc instead
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			pc_load <= 1'b0;
			pc_target <= dab_pkg::RST_WORD;
			branch_via_acc <= 1'b0;
		end else if (clk_en) begin
			pc_load <= take_second && is_jump(held.op) && next_cond;
			branch_via_acc <= take_first && (next_op == dab_pkg::DAB_OP_JUMP_VIA_ACC);
			if (take_second) begin
				pc_target <= word;
			end
		end
	end

	// ----------------------------------------------------------------
	// checks
	// ----------------------------------------------------------------
	sequence s_first(logic [15:0] m, logic [15:0] p);
		take_first && ((word & m) == p);
	endsequence

	sequence s_pair_done(dab_pkg::dab_op_t op);
		take_second && (held.op == op);
	endsequence

	AST_AUX_ADD_IMM: assert property (@(posedge clk) disable iff (!reset_n)
		s_first(dab_pkg::MSK_BYTE, dab_pkg::PAT_AUX_ADD_SHORT_IMM) |=> dec_valid
		&& dec.op == dab_pkg::DAB_OP_AUX_ADD_SHORT_IMM && dec.imm == {8'h00, $past(word[7:0])})
		else $error("short aux add misdecoded");

	AST_AUX_COMPARE: assert property (@(posedge clk) disable iff (!reset_n)
		s_first(dab_pkg::MSK_AUX_COMPARE_ZERO_REG, dab_pkg::PAT_AUX_COMPARE_ZERO_REG)
		|=> dec.op == dab_pkg::DAB_OP_AUX_COMPARE_ZERO_REG && dec.cmp_cond == $past(word[1:0]))
		else $error("aux compare misdecoded");

	AST_PAGE_IMM: assert property (@(posedge clk) disable iff (!reset_n)
		s_first(dab_pkg::MSK_PAGE_PTR_LOAD_IMM, dab_pkg::PAT_PAGE_PTR_LOAD_IMM)
		|=> dec.op == dab_pkg::DAB_OP_PAGE_PTR_LOAD_IMM && dec.imm == {7'h00, $past(word[8:0])})
		else $error("page immediate misdecoded");

	AST_PAGE_MEM: assert property (@(posedge clk) disable iff (!reset_n)
		s_first(dab_pkg::MSK_BYTE, dab_pkg::PAT_PAGE_PTR_LOAD_MEM)
		|=> dec_valid && dec.op == dab_pkg::DAB_OP_PAGE_PTR_LOAD_MEM)
		else $error("page memory load misdecoded");

	AST_AUX_POINTER: assert property (@(posedge clk) disable iff (!reset_n)
		s_first(dab_pkg::MSK_BYTE, dab_pkg::PAT_AUX_POINTER_LOAD)
		|=> dec.op == dab_pkg::DAB_OP_AUX_POINTER_LOAD && !fetch_second)
		else $error("aux pointer family misdecoded");

	// the pair may wait any number of cycles; the check starts at the second word itself
	AST_LONG_IMM: assert property (@(posedge clk) disable iff (!reset_n)
		s_pair_done(dab_pkg::DAB_OP_AUX_LOAD_LONG_IMM) |=> dec_valid
		&& dec.op == dab_pkg::DAB_OP_AUX_LOAD_LONG_IMM && dec.imm == $past(word))
		else $error("long immediate not taken from second word");

	AST_MCAND_GROUP: assert property (@(posedge clk) disable iff (!reset_n)
		take_first && word[15:8] inside {8'h3f, 8'h3e, 8'h5b} |=> dec_valid && (dec.op
		inside {dab_pkg::DAB_OP_MCAND_LOAD_ACC_MOVE, dab_pkg::DAB_OP_MCAND_LOAD_PROD_TO_ACC,
		dab_pkg::DAB_OP_MCAND_LOAD_SUB_PROD}))
		else $error("multiplicand load group misdecoded");

	AST_MULT_ACC_WITH_MOVE_WAIT: assert property (@(posedge clk) disable iff (!reset_n)
		s_first(dab_pkg::MSK_BYTE, dab_pkg::PAT_MULT_ACC_WITH_MOVE)
		|=> fetch_second && !dec_valid)
		else $error("two-word multiply issued before second word");

	AST_MULT_PREV: assert property (@(posedge clk) disable iff (!reset_n)
		take_first && word[15:9] == 7'h1d |=> dec_valid && dec.op == ($past(word[8])
		? dab_pkg::DAB_OP_MULT_SUB_PREV_PROD : dab_pkg::DAB_OP_MULT_ADD_PREV_PROD))
		else $error("multiply previous product misdecoded");

	AST_PROD_ADD: assert property (@(posedge clk) disable iff (!reset_n)
		s_first(dab_pkg::MSK_FULL, dab_pkg::PAT_PROD_ADD_TO_ACC)
		|=> dec.op == dab_pkg::DAB_OP_PROD_ADD_TO_ACC)
		else $error("product add misdecoded");

	AST_VIA_ACC: assert property (@(posedge clk) disable iff (!reset_n)
		s_first(dab_pkg::MSK_FULL, dab_pkg::PAT_JUMP_VIA_ACC) |=> branch_via_acc && !pc_load)
		else $error("accumulator jump not flagged");

	AST_AUX_NZ: assert property (@(posedge clk) disable iff (!reset_n)
		s_pair_done(dab_pkg::DAB_OP_JUMP_AUX_NONZERO) |=> pc_load == $past(cond_aux_nz))
		else $error("aux nonzero jump wrong");

	AST_FLAG_CLEAR: assert property (@(posedge clk) disable iff (!reset_n)
		s_pair_done(dab_pkg::DAB_OP_JUMP_FLAG_CLEAR) |=> pc_load == $past(cond_flag_clear))
		else $error("flag clear jump wrong");

	AST_ACC_POS: assert property (@(posedge clk) disable iff (!reset_n)
		s_pair_done(dab_pkg::DAB_OP_JUMP_ACC_POSITIVE) |=> pc_load == $past(cond_acc_pos))
		else $error("positive jump wrong");

	AST_ACC_NEG: assert property (@(posedge clk) disable iff (!reset_n)
		s_pair_done(dab_pkg::DAB_OP_JUMP_ACC_NEGATIVE) |=> pc_load == $past(cond_acc_neg))
		else $error("negative jump wrong");

	AST_PC_TARGET: assert property (@(posedge clk) disable iff (!reset_n)
		pc_load |-> pc_target == dec.imm && dec_valid)
		else $error("program counter target not second word");

	AST_INDIRECT: assert property (@(posedge clk) disable iff (!reset_n)
		take_first && !is_two_word(next_op) |=> dec.indirect == $past(word[7])
		&& dec.mem_field == $past(word[6:0]))
		else $error("address mode field wrong");

endmodule : dab_decoder

// ---- dab_fetch_model.sv ----
// fetch unit and datapath model feeding words and machine state to the decoder
`timescale 1ns/1ps
module dab_fetch_model (
	// clock
	input wire logic clk,
	// fetched words
	output logic word_valid,
	output logic [15:0] word,
	// machine state
	output logic [15:0] aux_cur,
	output logic [31:0] acc,
	output logic test_control_flag
);
	initial begin
		word_valid = 1'b0;
		word = 16'h0000;
		aux_cur = 16'h0000;
		acc = 32'h0000_0000;
		test_control_flag = 1'b0;
	end

	// presents one word for one edge; entered and left at a falling edge
	task automatic send(input logic [15:0] w);
		word_valid = 1'b1;
		word = w;
		@(negedge clk);
	endtask : send

	// released bus shows the inverse so a stale word is never taken for fresh
	task automatic idle();
		word_valid = 1'b0;
		word = ~word;
		@(negedge clk);
	endtask : idle

	task automatic set_state(input logic [15:0] a, input logic [31:0] ac, input logic f);
		aux_cur = a;
		acc = ac;
		test_control_flag = f;
	endtask : set_state
endmodule : dab_fetch_model

// ---- dab_decoder_test.sv ----
// self-checking bench for the auxiliary, multiplier and branch decoder
`timescale 1ns/1ps
module dab_decoder_test;
	// kind: 0 op only, 1 immediate, 2 memory reference, 3 compare condition
	typedef struct packed {
		logic [15:0] w;
		dab_pkg::dab_op_t op;
		logic [15:0] imm;
		logic [1:0] kind;
	} dab_row_t;
	typedef struct packed {
		logic [15:0] w1;
		logic [15:0] w2;
		logic [15:0] aux;
		logic [31:0] acc;
		logic flag;
		dab_pkg::dab_op_t op;
		logic load;
	} dab_pair_t;

	// ----------------------------------------------------------------
	// signals and instances
	// ----------------------------------------------------------------
	logic clk = 1'b0;
	logic reset_n = 1'b0;
	logic clk_en = 1'b1;
	logic word_valid, test_control_flag, dec_valid, fetch_second, pc_load, branch_via_acc;
	logic [15:0] word, aux_cur, pc_target;
	logic [31:0] acc;
	dab_pkg::dab_dec_t dec;
	int n_errors = 0;
	int checks = 0;

	always #25 clk = ~clk;

	dab_fetch_model u_dab_fetch_model (.clk(clk), .word_valid(word_valid), .word(word),
		.aux_cur(aux_cur), .acc(acc), .test_control_flag(test_control_flag));
	dab_decoder u_dab_decoder (.clk(clk), .reset_n(reset_n), .clk_en(clk_en),
		.word_valid(word_valid), .word(word), .aux_cur(aux_cur), .acc(acc),
		.test_control_flag(test_control_flag), .dec(dec), .dec_valid(dec_valid),
		.fetch_second(fetch_second), .pc_load(pc_load), .pc_target(pc_target),
		.branch_via_acc(branch_via_acc));

	// ----------------------------------------------------------------
	// case tables
	// ----------------------------------------------------------------
	dab_row_t rows [21] = '{
		'{16'h7e12, dab_pkg::DAB_OP_AUX_ADD_SHORT_IMM, 16'h0012, 2'h1},
		'{16'h7eff, dab_pkg::DAB_OP_AUX_ADD_SHORT_IMM, 16'h00ff, 2'h1},
		'{16'hce50, dab_pkg::DAB_OP_AUX_COMPARE_ZERO_REG, 16'h0000, 2'h3},
		'{16'hce51, dab_pkg::DAB_OP_AUX_COMPARE_ZERO_REG, 16'h0001, 2'h3},
		'{16'hce52, dab_pkg::DAB_OP_AUX_COMPARE_ZERO_REG, 16'h0002, 2'h3},
		'{16'hce53, dab_pkg::DAB_OP_AUX_COMPARE_ZERO_REG, 16'h0003, 2'h3},
		'{16'hce54, dab_pkg::DAB_OP_NONE, 16'h0000, 2'h0},
		'{16'hc800, dab_pkg::DAB_OP_PAGE_PTR_LOAD_IMM, 16'h0000, 2'h1},
		'{16'hc9ff, dab_pkg::DAB_OP_PAGE_PTR_LOAD_IMM, 16'h01ff, 2'h1},
		'{16'h52a5, dab_pkg::DAB_OP_PAGE_PTR_LOAD_MEM, 16'h0000, 2'h2},
		'{16'h5500, dab_pkg::DAB_OP_AUX_POINTER_LOAD, 16'h0000, 2'h0},
		'{16'h55a8, dab_pkg::DAB_OP_AUX_POINTER_LOAD, 16'h0000, 2'h0},
		'{16'h3f81, dab_pkg::DAB_OP_MCAND_LOAD_ACC_MOVE, 16'h0000, 2'h2},
		'{16'h3e12, dab_pkg::DAB_OP_MCAND_LOAD_PROD_TO_ACC, 16'h0000, 2'h2},
		'{16'h5b7f, dab_pkg::DAB_OP_MCAND_LOAD_SUB_PROD, 16'h0000, 2'h2},
		'{16'h3a80, dab_pkg::DAB_OP_MULT_ADD_PREV_PROD, 16'h0000, 2'h2},
		'{16'h3b05, dab_pkg::DAB_OP_MULT_SUB_PREV_PROD, 16'h0000, 2'h2},
		'{16'hce14, dab_pkg::DAB_OP_PROD_ADD_TO_ACC, 16'h0000, 2'h0},
		'{16'hce15, dab_pkg::DAB_OP_NONE, 16'h0000, 2'h0},
		'{16'hce25, dab_pkg::DAB_OP_JUMP_VIA_ACC, 16'h0000, 2'h0},
		'{16'hfb00, dab_pkg::DAB_OP_NONE, 16'h0000, 2'h0}
	};
	dab_pair_t pairs [11] = '{
		'{16'hd500, 16'h1234, 16'h0, 32'h0, 1'b0, dab_pkg::DAB_OP_AUX_LOAD_LONG_IMM, 1'b0},
		'{16'h7c85, 16'habcd, 16'h0, 32'h0, 1'b0, dab_pkg::DAB_OP_MULT_ACC_WITH_MOVE, 1'b0},
		'{16'hfb80, 16'h2000, 16'h0, 32'h0, 1'b0, dab_pkg::DAB_OP_JUMP_AUX_NONZERO, 1'b0},
		'{16'hfb81, 16'h2001, 16'h1, 32'h0, 1'b0, dab_pkg::DAB_OP_JUMP_AUX_NONZERO, 1'b1},
		'{16'hf880, 16'h3000, 16'h0, 32'h0, 1'b0, dab_pkg::DAB_OP_JUMP_FLAG_CLEAR, 1'b1},
		'{16'hf8ff, 16'h3001, 16'h0, 32'h0, 1'b1, dab_pkg::DAB_OP_JUMP_FLAG_CLEAR, 1'b0},
		'{16'hf180, 16'h4000, 16'h0, 32'h0, 1'b0, dab_pkg::DAB_OP_JUMP_ACC_POSITIVE, 1'b0},
		'{16'hf180, 16'h4001, 16'h0, 32'h1, 1'b0, dab_pkg::DAB_OP_JUMP_ACC_POSITIVE, 1'b1},
		'{16'hf180, 16'h4002, 16'h0, 32'h80000000, 1'b0, dab_pkg::DAB_OP_JUMP_ACC_POSITIVE, 1'b0},
		'{16'hf380, 16'h5000, 16'h0, 32'hffffffff, 1'b0, dab_pkg::DAB_OP_JUMP_ACC_NEGATIVE, 1'b1},
		'{16'hf380, 16'h5001, 16'h0, 32'h0, 1'b0, dab_pkg::DAB_OP_JUMP_ACC_NEGATIVE, 1'b0}
	};

	// ----------------------------------------------------------------
	// compare and closing tasks
	// ----------------------------------------------------------------
	task automatic chk1(input string name, input logic exp, input logic got);
		checks++;
		if (got !== exp) begin
			n_errors++;
			$display("[FAIL] %s expected %b seen %b", name, exp, got);
		end
	endtask : chk1

	task automatic chk16(input string name, input logic [15:0] exp, input logic [15:0] got);
		checks++;
		if (got !== exp) begin
			n_errors++;
			$display("[FAIL] %s expected %h seen %h", name, exp, got);
		end
	endtask : chk16

	task automatic chk_op(input dab_pkg::dab_op_t exp, input dab_pkg::dab_op_t got);
		checks++;
		if (got !== exp) begin
			n_errors++;
			$display("[FAIL] op expected %0d seen %0d", exp, got);
		end
	endtask : chk_op

	task automatic end_of_test();
		if (n_errors == 0 && checks > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask : end_of_test

	// ----------------------------------------------------------------
	// main sequence
	// ----------------------------------------------------------------
	initial begin
		dab_row_t r;
		dab_pair_t p;
		repeat (5) @(negedge clk);
		reset_n = 1'b1;
		chk_op(dab_pkg::DAB_OP_NONE, dec.op);
		chk1("dec_valid", 1'b0, dec_valid);
		chk1("fetch_second", 1'b0, fetch_second);
		chk1("pc_load", 1'b0, pc_load);
		chk16("pc_target", 16'h0000, pc_target);
		// single words back to back
		foreach (rows[i]) begin
			r = rows[i];
			u_dab_fetch_model.send(r.w);
			chk1("dec_valid", 1'b1, dec_valid);
			chk_op(r.op, dec.op);
			chk1("branch_via_acc", r.op == dab_pkg::DAB_OP_JUMP_VIA_ACC, branch_via_acc);
			if (r.kind == 2'h1) chk16("imm", r.imm, dec.imm);
			if (r.kind == 2'h2) chk1("indirect", r.w[7], dec.indirect);
			if (r.kind == 2'h2) chk16("mem_field", {9'h0, r.w[6:0]}, {9'h0, dec.mem_field});
			if (r.kind == 2'h3) chk16("cmp_cond", r.imm, {14'h0, dec.cmp_cond});
		end
		u_dab_fetch_model.idle();
		chk1("dec_valid", 1'b0, dec_valid);
		// two-word forms back to back
		foreach (pairs[i]) begin
			p = pairs[i];
			u_dab_fetch_model.set_state(p.aux, p.acc, p.flag);
			u_dab_fetch_model.send(p.w1);
			chk1("fetch_second", 1'b1, fetch_second);
			chk1("dec_valid", 1'b0, dec_valid);
			u_dab_fetch_model.send(p.w2);
			chk1("dec_valid", 1'b1, dec_valid);
			chk_op(p.op, dec.op);
			chk16("imm", p.w2, dec.imm);
			chk16("pc_target", p.w2, pc_target);
			chk1("pc_load", p.load, pc_load);
			chk1("fetch_second", 1'b0, fetch_second);
			if (p.op == dab_pkg::DAB_OP_AUX_LOAD_LONG_IMM) chk16("aux_sel", {13'h0, p.w1[10:8]},
				{13'h0, dec.aux_sel});
		end
		// disabled clock enable freezes the decode
		clk_en = 1'b0;
		u_dab_fetch_model.send(16'h7e44);
		chk1("dec_valid", 1'b1, dec_valid);
		chk_op(dab_pkg::DAB_OP_JUMP_ACC_NEGATIVE, dec.op);
		chk1("pc_load", 1'b0, pc_load);
		clk_en = 1'b1;
		// reset in the middle of a pair drops the pending first word
		u_dab_fetch_model.send(16'hfb80);
		chk1("fetch_second", 1'b1, fetch_second);
		u_dab_fetch_model.idle();
		reset_n = 1'b0;
		@(negedge clk);
		reset_n = 1'b1;
		chk1("fetch_second", 1'b0, fetch_second);
		u_dab_fetch_model.send(16'h7e01);
		chk_op(dab_pkg::DAB_OP_AUX_ADD_SHORT_IMM, dec.op);
		chk16("imm", 16'h0001, dec.imm);
		u_dab_fetch_model.idle();
		end_of_test();
	end

	// about 55 cycles of traffic; a hang is cut off well past that
	initial begin
		repeat (2000) @(posedge clk);
		n_errors++;
		end_of_test();
	end
endmodule : dab_decoder_test
